// ==== rtl/fhr_pkg.sv ====
// fhr_pkg: register map, field layout, reset values and ramp timing for the
// three-channel fan hysteresis and ramp controller.
// assumes: 125 MHz clk_in; temperatures are whole degrees, signed 8-bit.
package fhr_pkg;
   localparam logic [7:0] ADDR_SLOW_CFG      = 8'h10;
   localparam logic [7:0] ADDR_RAMP_A        = 8'h62;
   localparam logic [7:0] ADDR_RAMP_B        = 8'h63;
   localparam logic [7:0] ADDR_HYST_R1_LOC   = 8'h6d;
   localparam logic [7:0] ADDR_HYST_R2       = 8'h6e;
   localparam logic [7:0] ADDR_TEST_EN       = 8'h6f;
   localparam logic [7:0] ADDR_PRESENCE      = 8'h73;

   localparam logic [7:0] RST_SLOW_CFG       = 8'h00;
   localparam logic [7:0] RST_RAMP_A         = 8'h00;
   localparam logic [7:0] RST_RAMP_B         = 8'h00;
   localparam logic [7:0] RST_HYST_R1_LOC    = 8'h44;
   localparam logic [7:0] RST_HYST_R2        = 8'h40;
   localparam logic [7:0] RST_TEST_EN        = 8'h00;
   localparam logic [7:0] RST_PRESENCE       = 8'h00;
   localparam logic [7:0] DUTY_FULL          = 8'hff;
   localparam logic [7:0] DUTY_OFF           = 8'h00;

   // field positions
   localparam int HYST_R1_LSB    = 4;
   localparam int HYST_LOC_LSB   = 0;
   localparam int HYST_R2_LSB    = 4;
   localparam int HYST_W         = 4;
   localparam int KEEP_SPIN1_BIT = 5;
   localparam int KEEP_SPIN2_BIT = 6;
   localparam int KEEP_SPIN3_BIT = 7;
   localparam int R1_CODE_LSB    = 0;
   localparam int LOC_CODE_LSB   = 0;
   localparam int R2_CODE_LSB    = 4;
   localparam int CODE_W         = 3;
   localparam int SLOW_R1_BIT    = 0;
   localparam int SLOW_LOC_BIT   = 1;
   localparam int SLOW_R2_BIT    = 2;
   localparam int STRETCH_BIT    = 7;
   localparam int TEST_EN_BIT    = 0;
   localparam int DETECT_GO_BIT  = 0;
   localparam int PRESENT_LSB    = 1;

   localparam int SLOW_FACTOR    = 4;
   localparam int CLK_MHZ        = 125;
   localparam int DUTY_STEPS     = 255;
   localparam int DETECT_TIME_US = 5000;
   localparam int DETECT_CYCLES  = DETECT_TIME_US * CLK_MHZ;

   // full-scale ramp times in tenths of a second, normal then stretched
   localparam int RAMP_DS [0:7]  = '{375, 188, 125, 75, 47, 31, 16, 8};
   localparam int RAMP_XS [0:7]  = '{522, 261, 174, 104, 65, 44, 22, 11};
   // cycles per duty step: tenths * 12.5e6 / 255, rounded down
   localparam int STEP_DIV       = 10 * DUTY_STEPS;
endpackage : fhr_pkg

// ==== rtl/fhr_ramp.sv ====
// fhr_ramp: one fan output's duty slew limiter.
// assumes: tick period chosen by caller; target may change any cycle.
`timescale 1ns/10ps
module fhr_ramp #(
   parameter int TICK_W = 32
) (
   input  wire logic              clk_in,      // system clock
   input  wire logic              rst_in,      // sync reset, high
   input  wire logic [TICK_W-1:0] period_in,   // cycles per duty step, minus one
   input  wire logic              jump_in,     // skip ramp, take target now
   input  wire logic [7:0]        target_in,   // wanted duty
   output logic      [7:0]        duty_out     // ramped duty
);
   logic [TICK_W-1:0] cnt_q;
   logic [7:0]        duty_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || jump_in || cnt_q >= period_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         duty_q <= fhr_pkg::DUTY_FULL;
      end else if (jump_in) begin
         duty_q <= target_in;
      end else if (cnt_q >= period_in) begin
         if (duty_q < target_in) begin
            duty_q <= duty_q + 8'h01;
         end else if (duty_q > target_in) begin
            duty_q <= duty_q - 8'h01;
         end
      end
   end

   assign duty_out = duty_q;
endmodule : fhr_ramp

// ==== rtl/fhr_top.sv ====
// fhr_top: hysteresis, critical limit, keep-spin, ramp and presence logic for
// three fan outputs fed by remote-1, local and remote-2 temperature channels.
// assumes: a serial-bus front end gives a byte register port; temperatures,
// limits, minimum duties and curve duties arrive as synchronous inputs.
//
// Overview of operation
// - four-bit hysteresis field per channel
// - hysteresis fields reset to four degrees
// - hysteresis counted in whole degrees, 1..15
// - zero hysteresis disables it
// - one hysteresis serves on/off and critical release
// - over critical limit: all fans full
// - keep-spin clear: off below min minus hysteresis
// - keep-spin set: minimum duty below threshold
// - always-on fan holds minimum from below min minus hysteresis until above min
// - channel slow bits make ramps four times slower
// - slow factor stacks on code and stretch
// - stretch bit lengthens all ramps 39.2 percent
// - remote-1 ramp code in register a bits 2:0
// - local and remote-2 codes in register b
// - codes select 37.5 down to 0.8 s
// - stretched codes select 52.2 down to 1.1 s
// - presence results in bits 3:1
// - detection sinks pin, high means present
// - low core voltage sets status, raises alert if alert enabled
// - low core voltage freezes critical monitoring
// - test enable bit selects board test mode
// - power-up: monitoring off, outputs full duty
`timescale 1ns/10ps
module fhr_top #(
   parameter int DETECT_CYCLES = fhr_pkg::DETECT_CYCLES,
   parameter int CLK_MHZ       = fhr_pkg::CLK_MHZ
) (
   input  wire logic        clk_in,             // system clock, 125 MHz
   input  wire logic        rst_in,             // sync reset, high
   input  wire logic        reg_wr_in,          // register write strobe
   input  wire logic        reg_rd_in,          // register read strobe
   input  wire logic [7:0]  reg_addr_in,        // register address
   input  wire logic [7:0]  reg_wdata_in,       // write data
   output logic      [7:0]  reg_rdata_out,      // read data
   input  wire logic        monitor_en_in,      // host has started monitoring
   input  wire logic [23:0] temp_in,            // r2,loc,r1 temperatures
   input  wire logic [23:0] tmin_in,            // r2,loc,r1 minimum temps
   input  wire logic [23:0] tcrit_in,           // r2,loc,r1 critical limits
   input  wire logic [23:0] min_duty_in,        // out3..out1 minimum duties
   input  wire logic [23:0] curve_duty_in,      // out3..out1 curve duties
   input  wire logic [5:0]  out_chan_in,        // out3..out1 channel select
   input  wire logic        core_voltage_low_in, // core voltage under limit
   input  wire logic        alert_en_in,        // alert enable
   input  wire logic [2:0]  pwm_pin_in,         // level seen on fan pins
   output logic      [23:0] duty_out,           // out3..out1 duties
   output logic      [2:0]  pin_sink_out,       // detection sink on
   output logic             core_status_out,    // core-low status bit
   output logic             alert_out,          // alert request
   output logic             crit_active_out,    // critical forcing active
   output logic             test_mode_out       // board test mode
);
   logic [7:0]  slow_cfg_q;
   logic [7:0]  ramp_a_q;
   logic [7:0]  ramp_b_q;
   logic [7:0]  hyst_a_q;
   logic [7:0]  hyst_b_q;
   logic [7:0]  test_q;
   logic        detect_q;
   logic [2:0]  present_q;
   logic [31:0] det_cnt_q;
   logic [2:0]  crit_q;
   logic [2:0]  on_q;
   logic        crit_any_q;
   logic signed [9:0] temp_s [3];
   logic signed [9:0] tmin_s [3];
   logic signed [9:0] crit_s [3];
   logic signed [9:0] hyst_s [3];
   logic        core_stat_q;
   logic        core_low_q;
   logic [7:0]  rdata_q;
   logic [23:0] duty_q;
   logic        alert_q;
   logic [23:0] ramp_duty;
   logic [7:0]  hyst [3];
   logic [2:0]  code [3];
   logic [2:0]  slow;
   logic [2:0]  keep;

   assign hyst[0] = {4'h0, hyst_a_q[fhr_pkg::HYST_R1_LSB +: fhr_pkg::HYST_W]};
   assign hyst[1] = {4'h0, hyst_a_q[fhr_pkg::HYST_LOC_LSB +: fhr_pkg::HYST_W]};
   assign hyst[2] = {4'h0, hyst_b_q[fhr_pkg::HYST_R2_LSB +: fhr_pkg::HYST_W]};
   assign code[0] = ramp_a_q[fhr_pkg::R1_CODE_LSB +: fhr_pkg::CODE_W];
   assign code[1] = ramp_b_q[fhr_pkg::LOC_CODE_LSB +: fhr_pkg::CODE_W];
   assign code[2] = ramp_b_q[fhr_pkg::R2_CODE_LSB +: fhr_pkg::CODE_W];
   assign slow = {slow_cfg_q[fhr_pkg::SLOW_R2_BIT], slow_cfg_q[fhr_pkg::SLOW_LOC_BIT],
                  slow_cfg_q[fhr_pkg::SLOW_R1_BIT]};
   assign keep = {ramp_a_q[fhr_pkg::KEEP_SPIN3_BIT], ramp_a_q[fhr_pkg::KEEP_SPIN2_BIT],
                  ramp_a_q[fhr_pkg::KEEP_SPIN1_BIT]};

   // cycles per duty step, minus one, for a channel
   function automatic logic [31:0] step_period(input logic [2:0] c, input logic st,
                                               input logic sl);
      logic [63:0] t;
      t = st ? 64'(fhr_pkg::RAMP_XS[c]) : 64'(fhr_pkg::RAMP_DS[c]);
      t = t * 64'(CLK_MHZ) * 64'd1000000 / 64'(fhr_pkg::STEP_DIV);
      if (sl) begin
         t = t * 64'(fhr_pkg::SLOW_FACTOR);
      end
      if (t == 64'd0) begin
         t = 64'd1;
      end
      step_period = t[31:0] - 32'd1;
   endfunction : step_period

   // register writes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         slow_cfg_q <= fhr_pkg::RST_SLOW_CFG;
         ramp_a_q   <= fhr_pkg::RST_RAMP_A;
         ramp_b_q   <= fhr_pkg::RST_RAMP_B;
         hyst_a_q   <= fhr_pkg::RST_HYST_R1_LOC;
         hyst_b_q   <= fhr_pkg::RST_HYST_R2;
         test_q     <= fhr_pkg::RST_TEST_EN;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            fhr_pkg::ADDR_SLOW_CFG:    slow_cfg_q <= reg_wdata_in;
            fhr_pkg::ADDR_RAMP_A:      ramp_a_q   <= reg_wdata_in;
            fhr_pkg::ADDR_RAMP_B:      ramp_b_q   <= reg_wdata_in;
            fhr_pkg::ADDR_HYST_R1_LOC: hyst_a_q   <= reg_wdata_in;
            fhr_pkg::ADDR_HYST_R2:     hyst_b_q   <= {reg_wdata_in[7:4], 4'h0};
            fhr_pkg::ADDR_TEST_EN:     test_q     <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // presence detection: start bit self-clears after the detection window
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         detect_q  <= 1'b0;
         det_cnt_q <= 32'd0;
         present_q <= 3'h0;
      end else if (detect_q) begin
         if (det_cnt_q >= 32'(DETECT_CYCLES - 1)) begin
            detect_q  <= 1'b0;
            present_q <= pwm_pin_in;
         end else begin
            det_cnt_q <= det_cnt_q + 32'd1;
         end
      end else if (reg_wr_in && reg_addr_in == fhr_pkg::ADDR_PRESENCE &&
                   reg_wdata_in[fhr_pkg::DETECT_GO_BIT]) begin
         detect_q  <= 1'b1;
         det_cnt_q <= 32'd0;
      end
   end

   // ten-bit signed copies so that a limit minus hysteresis cannot wrap
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         temp_s[i] = {{2{temp_in[8*i+7]}}, temp_in[8*i +: 8]};
         tmin_s[i] = {{2{tmin_in[8*i+7]}}, tmin_in[8*i +: 8]};
         crit_s[i] = {{2{tcrit_in[8*i+7]}}, tcrit_in[8*i +: 8]};
         hyst_s[i] = {2'b00, hyst[i]};
      end
   end

   // per-channel critical and on/off hysteresis
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         crit_q     <= 3'h0;
         on_q       <= 3'h0;
         crit_any_q <= 1'b0;
      end else begin
         crit_any_q <= |crit_q;
         if (monitor_en_in) begin
            for (int i = 0; i < 3; i++) begin
               if (!core_low_q) begin
                  if (temp_s[i] > crit_s[i]) begin
                     crit_q[i] <= 1'b1;
                  end else if (temp_s[i] < crit_s[i] - hyst_s[i] || hyst[i] == 8'h00) begin
                     crit_q[i] <= 1'b0;
                  end
               end
               if (temp_s[i] > tmin_s[i]) begin
                  on_q[i] <= 1'b1;
               end else if (temp_s[i] < tmin_s[i] - hyst_s[i]
                            || hyst[i] == 8'h00) begin
                  on_q[i] <= 1'b0;
               end
            end
         end
      end
   end

   // core voltage standby handling; set wins over nothing, status is level
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         core_low_q  <= 1'b0;
         core_stat_q <= 1'b0;
         alert_q     <= 1'b0;
      end else begin
         core_low_q  <= core_voltage_low_in;
         core_stat_q <= core_voltage_low_in;
         alert_q     <= core_voltage_low_in & alert_en_in;
      end
   end

   // ramp generators, one per output
   for (genvar g = 0; g < 3; g++) begin : g_out
      logic [1:0] ch;
      logic [7:0] target;
      logic       jump;
      assign ch = (out_chan_in[2*g +: 2] > 2'd2) ? 2'd0 : out_chan_in[2*g +: 2];
      always_comb begin
         jump   = 1'b0;
         target = curve_duty_in[8*g +: 8];
         if (!monitor_en_in) begin
            target = fhr_pkg::DUTY_FULL;
            jump   = 1'b1;
         end else if (|crit_q) begin
            target = fhr_pkg::DUTY_FULL;
            jump   = 1'b1;
         end else if (keep[g]) begin
            if (!on_q[ch] && curve_duty_in[8*g +: 8] < min_duty_in[8*g +: 8]) begin
               target = min_duty_in[8*g +: 8];
            end
         end else if (!on_q[ch]) begin
            target = fhr_pkg::DUTY_OFF;
         end
      end
      fhr_ramp #(.TICK_W(32)) u_ramp (
         .clk_in   (clk_in),
         .rst_in   (rst_in),
         .period_in(step_period(code[ch], slow_cfg_q[fhr_pkg::STRETCH_BIT], slow[ch])),
         .jump_in  (jump),
         .target_in(target),
         .duty_out (ramp_duty[8*g +: 8])
      );
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         duty_q <= {3{fhr_pkg::DUTY_FULL}};
      end else begin
         duty_q <= ramp_duty;
      end
   end

   // register reads
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            fhr_pkg::ADDR_SLOW_CFG:    rdata_q <= slow_cfg_q;
            fhr_pkg::ADDR_RAMP_A:      rdata_q <= ramp_a_q;
            fhr_pkg::ADDR_RAMP_B:      rdata_q <= ramp_b_q;
            fhr_pkg::ADDR_HYST_R1_LOC: rdata_q <= hyst_a_q;
            fhr_pkg::ADDR_HYST_R2:     rdata_q <= hyst_b_q;
            fhr_pkg::ADDR_TEST_EN:     rdata_q <= test_q;
            fhr_pkg::ADDR_PRESENCE:    rdata_q <= {4'h0, present_q, detect_q};
            default:                   rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_out   = rdata_q;
   assign duty_out        = duty_q;
   assign pin_sink_out    = {3{detect_q}};
   assign core_status_out = core_stat_q;
   assign alert_out       = alert_q;
   assign crit_active_out = crit_any_q;
   assign test_mode_out   = test_q[fhr_pkg::TEST_EN_BIT];
endmodule : fhr_top

// ==== bench/fhr_fan_model.sv ====
// fhr_fan_model: three fan pins as seen by the presence sink.
// assumes: a fitted fan pulls its pin up; an empty pin floats.
`timescale 1ns/10ps
module fhr_fan_model (
   input  wire logic       clk_in,     // clock
   input  wire logic [2:0] sink_in,    // device sink on
   input  wire logic [2:0] present_in, // fans fitted
   output logic      [2:0] pin_out     // pin levels
);
   logic [2:0] float_q = 3'h5;
   // an empty pin wanders every cycle unless sunk low
   always @(posedge clk_in) float_q <= ~float_q;
   assign pin_out = present_in | (~sink_in & float_q);
endmodule : fhr_fan_model

// ==== bench/fhr_checker.sv ====
// fhr_checker: port-level assertions for fhr_top.
// assumes: bound into every fhr_top; one clock domain.
`timescale 1ns/10ps
module fhr_checker #(
   parameter int DETECT_CYCLES = fhr_pkg::DETECT_CYCLES
) (
   input wire logic        clk_in,              // clock
   input wire logic        rst_in,              // sync reset
   input wire logic        reg_wr_in,           // write strobe
   input wire logic        reg_rd_in,           // read strobe
   input wire logic [7:0]  reg_addr_in,         // address
   input wire logic [7:0]  reg_wdata_in,        // write data
   input wire logic [7:0]  reg_rdata_out,       // read data
   input wire logic        monitor_en_in,       // monitoring on
   input wire logic [23:0] temp_in,             // temperatures
   input wire logic [23:0] tcrit_in,            // critical limits
   input wire logic        core_voltage_low_in, // core low
   input wire logic        alert_en_in,         // alert enable
   input wire logic [23:0] duty_out,            // duties
   input wire logic [2:0]  pin_sink_out,        // presence sink
   input wire logic        core_status_out,     // core status
   input wire logic        alert_out,           // alert
   input wire logic        crit_active_out,     // critical forcing
   input wire logic        test_mode_out        // board test mode
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_detect_start;
      reg_wr_in && reg_addr_in == 8'h73 && reg_wdata_in[0] && pin_sink_out == 3'h0;
   endsequence
   sequence s_hot_r1;
      (monitor_en_in && !core_voltage_low_in && $signed(temp_in[7:0]) > $signed(tcrit_in[7:0]))[*3];
   endsequence
   property p_off_full; (!monitor_en_in)[*4] |-> duty_out == 24'hffffff; endproperty
   a_off_full: assert property (p_off_full) else $error("duty not full, monitor off");
   property p_crit_full; crit_active_out[*3] |-> duty_out == 24'hffffff; endproperty
   a_crit_full: assert property (p_crit_full) else $error("duty not full, critical");
   property p_crit_set; s_hot_r1 |-> ##[0:2] crit_active_out; endproperty
   a_crit_set: assert property (p_crit_set) else $error("critical flag missing");
   property p_core_freeze; core_voltage_low_in[*3] |=> $stable(crit_active_out); endproperty
   a_core_freeze: assert property (p_core_freeze) else $error("critical moved, core low");
   property p_core_status;
      core_voltage_low_in |=> core_status_out && alert_out == $past(alert_en_in);
   endproperty
   a_core_status: assert property (p_core_status) else $error("core status or alert wrong");
   property p_test_mode;
      reg_wr_in && reg_addr_in == 8'h6f |=> test_mode_out == $past(reg_wdata_in[0]);
   endproperty
   a_test_mode: assert property (p_test_mode) else $error("test mode wrong");
   property p_hyst2_low; reg_rd_in && reg_addr_in == 8'h6e |=> reg_rdata_out[3:0] == 4'h0; endproperty
   a_hyst2_low: assert property (p_hyst2_low) else $error("hysteresis low nibble set");
   property p_sink_run; s_detect_start |=> (pin_sink_out == 3'h7)[*8]; endproperty
   a_sink_run: assert property (p_sink_run) else $error("sink not held");
   property p_ramp_step;
      (monitor_en_in && !crit_active_out)[*4]
         |-> (duty_out[7:0] - $past(duty_out[7:0])) inside {8'h00, 8'h01, 8'hff};
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("duty jumped");
endmodule : fhr_checker

bind fhr_top fhr_checker #(.DETECT_CYCLES(DETECT_CYCLES)) i_chk (.clk_in, .rst_in, .reg_wr_in,
   .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .monitor_en_in, .temp_in, .tcrit_in,
   .core_voltage_low_in, .alert_en_in, .duty_out, .pin_sink_out, .core_status_out, .alert_out,
   .crit_active_out, .test_mode_out);

// ==== bench/test_fhr_top.sv ====
// test_fhr_top: self-checking bench for fhr_top.
// assumes: fhr_checker bound in; fan pins come from fhr_fan_model.
`timescale 1ns/10ps
module test_fhr_top;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [7:0]  reg_addr_in = 8'h00;
   logic [7:0]  reg_wdata_in = 8'h00;
   logic        monitor_en_in = 1'b0;
   logic [23:0] temp_in = 24'h141414;
   logic [23:0] tmin_in = 24'h282828;
   logic [23:0] tcrit_in = 24'h505050;
   logic [23:0] min_duty_in = 24'h0;
   logic [23:0] curve_duty_in = 24'h0;
   logic [5:0]  out_chan_in = 6'h0;
   logic        core_voltage_low_in = 1'b0;
   logic        alert_en_in = 1'b0;
   logic [2:0]  fans = 3'h0;
   logic [2:0]  pwm_pin_in, pin_sink_out;
   logic [7:0]  reg_rdata_out, rv, d;
   logic [23:0] duty_out;
   logic        core_status_out, alert_out, crit_active_out, test_mode_out;
   logic [3:0]  hv [3];
   logic [7:0]  addrs [8] = '{8'h10, 8'h62, 8'h63, 8'h6d, 8'h6e, 8'h6f, 8'h73, 8'h00};
   logic [7:0]  rsts [8] = '{8'h00, 8'h00, 8'h00, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};
   int          error_cnt = 0;
   int          checks = 0;
   int          n;
   // slow clock figure for the ramp maths keeps one duty step within reach
   localparam int CLK_SIM = 1;

   fhr_top #(.DETECT_CYCLES(20), .CLK_MHZ(CLK_SIM)) i_dut (.clk_in, .rst_in, .reg_wr_in,
      .reg_rd_in, .reg_addr_in,
      .reg_wdata_in, .reg_rdata_out, .monitor_en_in, .temp_in, .tmin_in, .tcrit_in, .min_duty_in,
      .curve_duty_in, .out_chan_in, .core_voltage_low_in, .alert_en_in, .pwm_pin_in, .duty_out,
      .pin_sink_out, .core_status_out, .alert_out, .crit_active_out, .test_mode_out);
   fhr_fan_model i_fan (.clk_in, .sink_in(pin_sink_out), .present_in(fans), .pin_out(pwm_pin_in));

   initial begin
      forever #4 clk_in = ~clk_in;
   end

   task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_out
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_out({16'h0, got}, {16'h0, exp});
   endtask : chk_reg
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cyc(1);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = v;
      cyc(1);
      reg_wr_in = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      cyc(1);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      cyc(1);
      reg_rd_in = 1'b0;
      rv = reg_rdata_out;
   endtask : rd
   task automatic heat(input int c, input logic [7:0] t);
      temp_in[8*c +: 8] = t;
      cyc(5);
   endtask : heat
   // cycles per duty step for ramp code 7
   function automatic int step_cycles(input logic st, input logic sl);
      int t;
      t = (st ? fhr_pkg::RAMP_XS[7] : fhr_pkg::RAMP_DS[7]) * CLK_SIM * 1000000;
      t = t / fhr_pkg::STEP_DIV;
      return sl ? t * fhr_pkg::SLOW_FACTOR : t;
   endfunction : step_cycles
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   initial begin
      #(8 * 40000);
      error_cnt++;
      stop_test();
   end

   initial begin
      rv = 8'($urandom(22));
      min_duty_in = 24'($urandom());
      curve_duty_in = 24'($urandom());
      out_chan_in = 6'($urandom());
      cyc(5);
      rst_in = 1'b0;
      chk_out(duty_out, 24'hffffff);
      for (int i = 0; i < 8; i++) begin
         rd(addrs[i]);
         chk_reg(rv, rsts[i]);
      end
      for (int i = 0; i < 6; i++) begin
         d = (i == 5) ? 8'h01 : 8'($urandom());
         wr(addrs[i], d);
         rd(addrs[i]);
         chk_reg(rv, (i == 4) ? {d[7:4], 4'h0} : d);
      end
      chk_out({23'h0, test_mode_out}, 24'h1);
      wr(8'h6f, 8'h00);
      chk_out({23'h0, test_mode_out}, 24'h0);
      $display("test registers done");
      out_chan_in = 6'h0;
      min_duty_in = 24'hffffff;
      wr(8'h62, 8'h27);
      for (int s = 0; s < 3; s++) begin
         monitor_en_in = 1'b0;
         wr(8'h10, (s == 1) ? 8'h80 : {7'h0, s == 2});
         cyc(3);
         monitor_en_in = 1'b1;
         n = step_cycles(s == 1, s == 2);
         cyc(n - 20);
         chk_out(duty_out, 24'hffffff);
         cyc(40);
         chk_out(duty_out, 24'hfefeff);
      end
      $display("test ramp done");
      for (int p = 0; p < 3; p++) begin
         foreach (hv[c]) hv[c] = (p == 0) ? 4'hf : (p == 2) ? 4'h0 : 4'($urandom_range(14, 1));
         wr(8'h6d, {hv[0], hv[1]});
         wr(8'h6e, {hv[2], 4'h0});
         for (int c = 0; c < 3; c++) begin
            heat(c, 8'h51);
            chk_out({23'h0, crit_active_out}, 24'h1);
            chk_out(duty_out, 24'hffffff);
            heat(c, 8'h50 - 8'(hv[c]));
            if (hv[c] != 4'h0) chk_out({23'h0, crit_active_out}, 24'h1);
            heat(c, 8'h4f - 8'(hv[c]));
            chk_out({23'h0, crit_active_out}, 24'h0);
            heat(c, 8'h14);
         end
      end
      $display("test critical done");
      for (int a = 0; a < 2; a++) begin
         alert_en_in = a[0];
         core_voltage_low_in = 1'b1;
         cyc(3);
         chk_out({22'h0, core_status_out, alert_out}, {22'h0, 1'b1, a[0]});
         heat(0, 8'h51);
         chk_out({23'h0, crit_active_out}, 24'h0);
         core_voltage_low_in = 1'b0;
         cyc(5);
         chk_out({23'h0, crit_active_out}, 24'h1);
         heat(0, 8'h14);
      end
      chk_out({22'h0, core_status_out, alert_out}, 24'h0);
      $display("test core voltage done");
      monitor_en_in = 1'b0;
      for (int k = 0; k < 3; k++) begin
         fans = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'($urandom());
         wr(8'h73, 8'h01);
         rd(8'h73);
         chk_reg({7'h0, rv[0]}, 8'h01);
         chk_out({21'h0, pin_sink_out}, 24'h7);
         wr(8'h73, 8'h01);
         for (int i = 0; i < 100 && pin_sink_out !== 3'h0; i++) cyc(1);
         rd(8'h73);
         chk_reg({4'h0, rv[3:0]}, {4'h0, fans, 1'b0});
      end
      $display("test presence done");
      stop_test();
   end
endmodule : test_fhr_top
